// file: rtl/timer_cfg.svh
// Register indices, field positions, reset values and timing counts of the dual timer.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define TC_IDX_CTRL 8'h88
`define TC_IDX_MODE 8'h89
`define TC_IDX_TL0 8'h8a
`define TC_IDX_TL1 8'h8b
`define TC_IDX_TH0 8'h8c
`define TC_IDX_TH1 8'h8d
`define TC_IDX_IRQEN 8'h90
`define TC_IDX_ACK 8'h91

// ****************************************************************
// Field positions in the interrupt enable and acknowledge registers.
// ****************************************************************
`define TC_BIT_UNIT0 0
`define TC_BIT_UNIT1 1
`define TC_BIT_EXT0 2
`define TC_BIT_EXT1 3
`define TC_BIT_GLOBAL 4

// ****************************************************************
// Reset values.
// ****************************************************************
`define TC_RST_CTRL 8'h00
`define TC_RST_MODE 8'h00
`define TC_RST_COUNT 8'h00
`define TC_RST_IRQEN 5'h00

// ****************************************************************
// Timing: one peripheral cycle is six clock periods.
// ****************************************************************
`define TC_PER_CYCLE_CLKS 3'h6

// ****************************************************************
// Bus answers.
// ****************************************************************
`define TC_RESP_OKAY 2'h0
`define TC_RESP_SLVERR 2'h2

`endif

// file: rtl/timer_pkg.sv
// Types shared by the dual timer/counter.
package timer_pkg;

	// ****************************************************************
	// Operating modes and register layouts.
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD,
		MODE_SPLIT
	} timer_mode_t;

	typedef struct packed {
		logic gate;
		logic source;
		timer_mode_t mode;
	} unit_mode_t;

	typedef struct packed {
		logic ovf1;
		logic run1;
		logic ovf0;
		logic run0;
		logic ext1_flag;
		logic ext1_type;
		logic ext0_flag;
		logic ext0_type;
	} ctrl_t;

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic ovf;
	} count_step_t;

endpackage : timer_pkg

// file: rtl/dual_timer.sv
// Dual 8-bit-pair timer/counter with an AXI4-Lite register slave.
`include "timer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dual_timer
	import timer_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input wire logic aclk, // Peripheral clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [ADDR_W-1:0] awaddr, // Write address.
	input wire logic [2:0] awprot, // Write protection, unused.
	input wire logic awvalid, // Write address valid.
	output logic awready, // Write address ready.
	input wire logic [31:0] wdata, // Write data.
	input wire logic [3:0] wstrb, // Write byte enables.
	input wire logic wvalid, // Write data valid.
	output logic wready, // Write data ready.
	output logic [1:0] bresp, // Write response.
	output logic bvalid, // Write response valid.
	input wire logic bready, // Write response ready.
	input wire logic [ADDR_W-1:0] araddr, // Read address.
	input wire logic [2:0] arprot, // Read protection, unused.
	input wire logic arvalid, // Read address valid.
	output logic arready, // Read address ready.
	output logic [31:0] rdata, // Read data.
	output logic [1:0] rresp, // Read response.
	output logic rvalid, // Read data valid.
	input wire logic rready, // Read data ready.
	input wire logic count0_pin, // Unit 0 external count input.
	input wire logic count1_pin, // Unit 1 external count input.
	input wire logic ext_irq0_pin, // External interrupt 0 pin, active low.
	input wire logic ext_irq1_pin, // External interrupt 1 pin, active low.
	output logic irq_unit0, // Unit 0 interrupt request.
	output logic irq_unit1, // Unit 1 interrupt request.
	output logic irq_ext0, // External interrupt 0 request.
	output logic irq_ext1, // External interrupt 1 request.
	output logic unit1_overflow_pulse // Unit 1 overflow, baud source.
);

	// ****************************************************************
	// Functions
	// ****************************************************************

	// Turns a byte address into a register index; misaligned or out-of-range addresses give 8'h00.
	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		if (addr[1:0] != 2'h0 || addr[ADDR_W-1:10] != '0) begin
			idx = 8'h00;
		end
		return idx;
	endfunction : reg_index

	function automatic logic index_mapped(input logic [7:0] idx);
		return (idx >= `TC_IDX_CTRL && idx <= `TC_IDX_TH1) || idx == `TC_IDX_IRQEN ||
			idx == `TC_IDX_ACK;
	endfunction : index_mapped

	// One count step for modes 0 to 2; split mode steps the low byte alone.
	function automatic count_step_t count_step(input timer_mode_t mode,
		input logic [7:0] low, input logic [7:0] high, input logic inc);
		count_step_t s;
		s.low = low;
		s.high = high;
		s.ovf = 1'b0;
		if (inc) begin
			case (mode)
				MODE_13BIT: begin
					s.low = {low[7:5], low[4:0] + 5'h01};
					if (low[4:0] == 5'h1f) begin
						s.high = high + 8'h01;
						s.ovf = (high == 8'hff);
					end
				end
				MODE_16BIT: begin
					s.low = low + 8'h01;
					if (low == 8'hff) begin
						s.high = high + 8'h01;
						s.ovf = (high == 8'hff);
					end
				end
				MODE_RELOAD: begin
					if (low == 8'hff) begin
						s.low = high;
						s.ovf = 1'b1;
					end else begin
						s.low = low + 8'h01;
					end
				end
				default: begin
					s.low = low + 8'h01;
					s.ovf = (low == 8'hff);
				end
			endcase
		end
		return s;
	endfunction : count_step

	// ****************************************************************
	// Registers
	// ****************************************************************
	ctrl_t ctrl;
	logic [7:0] mode_reg;
	logic [7:0] tl0, th0, tl1, th1;
	logic [4:0] irq_en;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic w_lane0;
	logic [3:0] sync1, sync2;
	logic [1:0] samp, fall_evt;
	logic [1:0] ext_prev;
	logic [2:0] presc;
	logic tick;

	// ****************************************************************
	// Bus decode
	// ****************************************************************

	// A write commits once address and data are both held and no answer waits.
	wire logic wr_commit = !awready && !wready && !bvalid;
	wire logic [7:0] wr_idx = reg_index(aw_addr);
	wire logic wr_ok = index_mapped(wr_idx);
	wire logic wr_go = wr_commit && wr_ok && w_lane0;
	wire logic wr_ctrl = wr_go && wr_idx == `TC_IDX_CTRL;
	wire logic wr_mode = wr_go && wr_idx == `TC_IDX_MODE;
	wire logic wr_tl0 = wr_go && wr_idx == `TC_IDX_TL0;
	wire logic wr_tl1 = wr_go && wr_idx == `TC_IDX_TL1;
	wire logic wr_th0 = wr_go && wr_idx == `TC_IDX_TH0;
	wire logic wr_th1 = wr_go && wr_idx == `TC_IDX_TH1;
	wire logic wr_irqen = wr_go && wr_idx == `TC_IDX_IRQEN;
	wire logic wr_ack = wr_go && wr_idx == `TC_IDX_ACK;
	wire logic [7:0] wr_byte = w_data[7:0];
	wire logic [3:0] ack = wr_ack ? wr_byte[3:0] : 4'h0;

	// Read selection; the acknowledge register reads as zero.
	wire logic ar_take = arvalid && arready;
	wire logic [7:0] rd_idx = reg_index(araddr);
	wire logic rd_ok = index_mapped(rd_idx);
	wire logic [7:0] rd_byte =
		(rd_idx == `TC_IDX_CTRL) ? ctrl :
		(rd_idx == `TC_IDX_MODE) ? mode_reg :
		(rd_idx == `TC_IDX_TL0) ? tl0 :
		(rd_idx == `TC_IDX_TL1) ? tl1 :
		(rd_idx == `TC_IDX_TH0) ? th0 :
		(rd_idx == `TC_IDX_TH1) ? th1 :
		(rd_idx == `TC_IDX_IRQEN) ? {3'h0, irq_en} : 8'h00;

	// ****************************************************************
	// Counting control
	// ****************************************************************

	// Unit 1 owns the upper nibble of the mode register.
	wire unit_mode_t mode0 = unit_mode_t'(mode_reg[3:0]);
	wire unit_mode_t mode1 = unit_mode_t'(mode_reg[7:4]);
	wire logic split = (mode0.mode == MODE_SPLIT);

	// Gate pins are active-high enables here, taken after synchronisation.
	wire logic en0 = ctrl.run0 && (!mode0.gate || sync2[2]);
	// While unit 0 is split unit 1's run bit is taken away, so unit 1 runs free.
	wire logic run1_eff = split ? 1'b1 : ctrl.run1;
	wire logic en1 = run1_eff && (!mode1.gate || sync2[3]);
	wire logic inc0 = en0 && (mode0.source ? fall_evt[0] : tick);
	wire logic hold1 = (mode1.mode == MODE_SPLIT);
	wire logic inc1 = en1 && !hold1 && (mode1.source ? fall_evt[1] : tick);

	wire count_step_t step0 = count_step(mode0.mode, tl0, th0, inc0);
	wire count_step_t step1 = count_step(mode1.mode, tl1, th1, inc1);

	// The split high byte is a plain timer started by unit 1's run bit.
	wire logic inc0_high = split && ctrl.run1 && tick;
	wire logic ovf0_high = inc0_high && th0 == 8'hff;
	wire logic [7:0] next_th0 = inc0_high ? th0 + 8'h01 : step0.high;

	// Unit 1 loses its flag to the split high byte, but still feeds the baud output.
	wire logic set_ovf0 = step0.ovf;
	wire logic set_ovf1 = split ? ovf0_high : step1.ovf;

	// ****************************************************************
	// External interrupt detection
	// ****************************************************************
	wire logic [1:0] ext_low = ~sync2[3:2];
	wire logic [1:0] ext_fall = ext_prev & ~sync2[3:2];

	// Flags: software write first, then acknowledge-register clears, then hardware sets win.
	ctrl_t ctrl_w, next_ctrl;
	assign ctrl_w = wr_ctrl ? ctrl_t'(wr_byte) : ctrl;
	assign next_ctrl.run1 = ctrl_w.run1;
	assign next_ctrl.run0 = ctrl_w.run0;
	assign next_ctrl.ext1_type = ctrl_w.ext1_type;
	assign next_ctrl.ext0_type = ctrl_w.ext0_type;
	assign next_ctrl.ovf0 = set_ovf0 || (ctrl_w.ovf0 && !ack[`TC_BIT_UNIT0]);
	assign next_ctrl.ovf1 = set_ovf1 || (ctrl_w.ovf1 && !ack[`TC_BIT_UNIT1]);
	// Level mode tracks the pin and ignores service; edge mode latches falls.
	assign next_ctrl.ext0_flag = !ctrl_w.ext0_type ? ext_low[0] :
		(ext_fall[0] || (ctrl_w.ext0_flag && !ack[`TC_BIT_EXT0]));
	assign next_ctrl.ext1_flag = !ctrl_w.ext1_type ? ext_low[1] :
		(ext_fall[1] || (ctrl_w.ext1_flag && !ack[`TC_BIT_EXT1]));

	wire logic global_en = irq_en[`TC_BIT_GLOBAL];

	// ****************************************************************
	// Pin synchronisers and peripheral-cycle timing
	// ****************************************************************

	// Two flops on every pin; only the second stage is read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Interrupt pins reset to their idle high level, so no false low or fall follows reset.
			sync1 <= 4'hc;
			sync2 <= 4'hc;
		end else begin
			sync1 <= {ext_irq1_pin, ext_irq0_pin, count1_pin, count0_pin};
			sync2 <= sync1;
		end
	end

	// Tick marks the last clock of each six-clock peripheral cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc <= 3'h0;
			tick <= 1'b0;
		end else begin
			presc <= (presc == `TC_PER_CYCLE_CLKS - 3'h1) ? 3'h0 : presc + 3'h1;
			tick <= (presc == `TC_PER_CYCLE_CLKS - 3'h2);
		end
	end

	// Count pins are sampled once per peripheral cycle; high then low counts once.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samp <= 2'h0;
			fall_evt <= 2'h0;
			ext_prev <= 2'h3;
		end else begin
			ext_prev <= sync2[3:2];
			if (tick) begin
				samp <= sync2[1:0];
			end
			fall_evt <= tick ? (samp & ~sync2[1:0]) : 2'h0;
		end
	end

	// ****************************************************************
	// Register file and counters
	// ****************************************************************

	// A bus write to a count byte wins over counting in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= ctrl_t'(`TC_RST_CTRL);
			mode_reg <= `TC_RST_MODE;
			irq_en <= `TC_RST_IRQEN;
			tl0 <= `TC_RST_COUNT;
			th0 <= `TC_RST_COUNT;
			tl1 <= `TC_RST_COUNT;
			th1 <= `TC_RST_COUNT;
		end else begin
			ctrl <= next_ctrl;
			mode_reg <= wr_mode ? wr_byte : mode_reg;
			irq_en <= wr_irqen ? wr_byte[4:0] : irq_en;
			tl0 <= wr_tl0 ? wr_byte : step0.low;
			th0 <= wr_th0 ? wr_byte : next_th0;
			tl1 <= wr_tl1 ? wr_byte : step1.low;
			th1 <= wr_th1 ? wr_byte : step1.high;
		end
	end

	// Requests need the source enable and the global enable.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_unit0 <= 1'b0;
			irq_unit1 <= 1'b0;
			irq_ext0 <= 1'b0;
			irq_ext1 <= 1'b0;
			unit1_overflow_pulse <= 1'b0;
		end else begin
			irq_unit0 <= ctrl.ovf0 && irq_en[`TC_BIT_UNIT0] && global_en;
			irq_unit1 <= ctrl.ovf1 && irq_en[`TC_BIT_UNIT1] && global_en;
			irq_ext0 <= ctrl.ext0_flag && irq_en[`TC_BIT_EXT0] && global_en;
			irq_ext1 <= ctrl.ext1_flag && irq_en[`TC_BIT_EXT1] && global_en;
			unit1_overflow_pulse <= step1.ovf;
		end
	end

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************

	// Address and data are held independently; the response follows both.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `TC_RESP_OKAY;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_lane0 <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data <= wdata;
				w_lane0 <= wstrb[0];
			end
			if (wr_commit) begin
				bvalid <= 1'b1;
				bresp <= wr_ok ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************

	// Reads have no side effects; one is answered the cycle after it is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `TC_RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h000000, rd_ok ? rd_byte : 8'h00};
				rresp <= rd_ok ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule : dual_timer
`default_nettype wire

// file: tb/dual_timer_properties.sv
// Concurrent checks on the dual timer ports.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_properties (
	input wire logic aclk, // Clock.
	input wire logic aresetn, // Reset, active low.
	input wire logic awvalid, // Write address valid.
	input wire logic awready, // Write address ready.
	input wire logic wvalid, // Write data valid.
	input wire logic wready, // Write data ready.
	input wire logic bvalid, // Write answer valid.
	input wire logic arvalid, // Read address valid.
	input wire logic arready, // Read address ready.
	input wire logic [31:0] rdata, // Read data.
	input wire logic rvalid, // Read answer valid.
	input wire logic irq_unit1, // Unit 1 request.
	input wire logic unit1_overflow_pulse // Unit 1 overflow.
);
	// One clock domain; nothing is judged while reset is low.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A write taken in full is answered within two edges.
	chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write not answered");
	chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read not answered");
	chk_write_busy: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	chk_read_busy: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	// Registers are one byte wide, so the upper read lanes stay zero.
	chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	chk_reset_quiet: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !irq_unit1)
		else $error("outputs active after reset");
	chk_pulse_single: assert property (unit1_overflow_pulse |=> !unit1_overflow_pulse)
		else $error("overflow pulse too long");
	// Counting advances once per six clocks, so overflows cannot come closer.
	chk_pulse_spacing: assert property ($rose(unit1_overflow_pulse) |=> !unit1_overflow_pulse [*5])
		else $error("overflows closer than six clocks");
endmodule : dual_timer_properties

bind dual_timer dual_timer_properties u_dual_timer_properties (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
	.irq_unit1(irq_unit1), .unit1_overflow_pulse(unit1_overflow_pulse));
`default_nettype wire

// file: tb/count_pin_model.sv
// Behavioural source of falling edges on the external count pins.
`timescale 1ns/1ps
`default_nettype none
module count_pin_model (
	input wire logic aclk, // Clock.
	input wire logic start, // Begins a burst.
	input wire logic [3:0] edges, // Falling edges in the burst.
	output wire logic pin, // Count pin level.
	output wire logic busy // Burst in progress.
);
	logic level = 1'b1;
	logic [4:0] left = 5'h00;
	logic [3:0] hold = 4'h0;
	assign pin = level;
	assign busy = left != 5'h00;
	// Each level stands twelve clocks, so the timer samples every level once at least.
	always @(posedge aclk) begin
		if (start && !busy) begin
			left <= {edges, 1'b0};
			hold <= 4'h0;
		end else if (busy) begin
			hold <= (hold == 4'hb) ? 4'h0 : hold + 4'h1;
			if (hold == 4'hb) begin
				level <= ~level;
				left <= left - 5'h01;
			end
		end
	end
endmodule : count_pin_model
`default_nettype wire

// file: tb/dual_timer_counter_modes_test.sv
// Self-checking bench for the dual timer/counter.
`include "timer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_modes_test
	import timer_pkg::*;
;
	typedef struct {
		logic [7:0] idx;
		logic [7:0] wd;
		logic [7:0] rd;
		logic [1:0] resp;
	} row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic ext0_pin = 1'b1, ext1_pin = 1'b1, start = 1'b0;
	logic [3:0] edges = 4'h0;
	wire logic awready, wready, bvalid, arready, rvalid, cpin, busy, irq1, pulse;
	wire logic irq0, irqx0, irqx1;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	int errors = 0;
	int comparisons = 0;
	int n;
	logic [7:0] d;
	logic [1:0] r;
	ctrl_t c;
	// Plain register cases: write, then read back; the last row is an unmapped place.
	row_t rows [5] = '{
		'{`TC_IDX_MODE, 8'ha5, 8'ha5, `TC_RESP_OKAY},
		'{`TC_IDX_TH0, 8'h5a, 8'h5a, `TC_RESP_OKAY},
		'{`TC_IDX_IRQEN, 8'h1f, 8'h1f, `TC_RESP_OKAY},
		'{`TC_IDX_ACK, 8'h0f, 8'h00, `TC_RESP_OKAY},
		'{8'h8e, 8'h77, 8'h00, `TC_RESP_SLVERR}};

	dual_timer u_dual_timer (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .count0_pin(cpin), .count1_pin(cpin),
		.ext_irq0_pin(ext0_pin), .ext_irq1_pin(ext1_pin), .irq_unit0(irq0), .irq_unit1(irq1),
		.irq_ext0(irqx0), .irq_ext1(irqx1), .unit1_overflow_pulse(pulse));
	count_pin_model m_pins (.aclk(aclk), .start(start), .edges(edges), .pin(cpin), .busy(busy));

	// Verdict, mismatch report and comparison helpers.
	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task automatic fail(input string m);
		errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask : fail
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
			fail($sformatf("got %h expected %h", got, exp));
	endtask : check
	task automatic bound(input int k);
		if (k >= 60) begin
			fail("wait ran out");
			conclude();
		end
	endtask : bound
	// Bus cycles hold each channel until its own ready is seen at an edge.
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		// Bready stays high afterwards, so back-to-back writes never toggle it in one step.
		r = bresp;
		bound(n);
	endtask : wr
	task automatic rd(input logic [7:0] idx);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata[7:0];
		r = rresp;
		bound(n);
	endtask : rd
	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		rd(idx);
		check(d, exp);
	endtask : rc
	// Edge count to the next overflow pulse, bounded.
	task automatic wait_pulse();
		for (n = 1; n < 60; n++) begin
			@(posedge aclk);
			if (pulse === 1'b1) break;
		end
		bound(n);
	endtask : wait_pulse
	task automatic burst(input logic [3:0] k);
		edges <= k;
		start <= 1'b1;
		@(posedge aclk);
		start <= 1'b0;
		for (n = 0; n < 60; n++) begin
			repeat (8) @(posedge aclk);
			if (busy === 1'b0) break;
		end
		bound(n);
	endtask : burst

	initial forever #20 aclk = ~aclk;

	// Main sequence: reset values first, then the table, then the mode scenarios.
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++) begin
			rc(8'h88 + 8'(i), `TC_RST_CTRL);
		end
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			check({6'h0, r}, {6'h0, rows[i].resp});
			rd(rows[i].idx);
			check({6'h0, r}, {6'h0, rows[i].resp});
			if (rows[i].resp == `TC_RESP_OKAY)
				check(d, rows[i].rd);
		end
		// Reload mode: two ticks from 0xfe to overflow, then reload from the high byte.
		wr(`TC_IDX_MODE, 8'h20);
		wr(`TC_IDX_TH1, 8'hfe);
		wr(`TC_IDX_TL1, 8'hfe);
		wr(`TC_IDX_IRQEN, 8'h12);
		wr(`TC_IDX_CTRL, 8'h40);
		wait_pulse();
		wait_pulse();
		check(n[7:0], 8'h0c);
		@(posedge aclk);
		check({7'h0, irq1}, 8'h01);
		wr(`TC_IDX_IRQEN, 8'h02);
		@(posedge aclk);
		check({7'h0, irq1}, 8'h00);
		wr(`TC_IDX_CTRL, 8'h80);
		rc(`TC_IDX_CTRL, 8'h80);
		rc(`TC_IDX_TH1, 8'hfe);
		wr(`TC_IDX_ACK, 8'h02);
		rc(`TC_IDX_CTRL, 8'h00);
		// Gated 16-bit event counting: the low gate pin blocks edges.
		wr(`TC_IDX_MODE, 8'hd0);
		wr(`TC_IDX_TL1, 8'hff);
		wr(`TC_IDX_TH1, 8'h12);
		wr(`TC_IDX_CTRL, 8'h40);
		ext1_pin <= 1'b0;
		burst(4'h2);
		rc(`TC_IDX_TL1, 8'hff);
		ext1_pin <= 1'b1;
		burst(4'h3);
		rc(`TC_IDX_TL1, 8'h02);
		rc(`TC_IDX_TH1, 8'h13);
		// Thirteen-bit mode: one tick rolls 0x1f/0xff over; mode 3 then holds the count.
		wr(`TC_IDX_CTRL, 8'h00);
		wr(`TC_IDX_MODE, 8'h00);
		wr(`TC_IDX_TL1, 8'hff);
		wr(`TC_IDX_TH1, 8'hff);
		wr(`TC_IDX_CTRL, 8'h40);
		wait_pulse();
		wr(`TC_IDX_MODE, 8'h30);
		rc(`TC_IDX_TL1, 8'he0);
		rc(`TC_IDX_TH1, 8'h00);
		// Split mode: the high byte runs on the unit 1 run bit, the low byte stays idle.
		wr(`TC_IDX_CTRL, 8'h00);
		wr(`TC_IDX_ACK, 8'h03);
		wr(`TC_IDX_MODE, 8'h33);
		wr(`TC_IDX_TH0, 8'hff);
		wr(`TC_IDX_TL0, 8'h33);
		wr(`TC_IDX_CTRL, 8'h40);
		repeat (14) @(posedge aclk);
		rc(`TC_IDX_CTRL, 8'hc0);
		rc(`TC_IDX_TL0, 8'h33);
		// External pin 0: level mode follows the pin, edge mode latches until serviced.
		ext0_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		rd(`TC_IDX_CTRL);
		c = ctrl_t'(d);
		check({7'h0, c.ext0_flag}, 8'h01);
		ext0_pin <= 1'b1;
		wr(`TC_IDX_CTRL, 8'h01);
		ext0_pin <= 1'b0;
		repeat (4) @(posedge aclk);
		ext0_pin <= 1'b1;
		rd(`TC_IDX_CTRL);
		c = ctrl_t'(d);
		check({7'h0, c.ext0_flag}, 8'h01);
		wr(`TC_IDX_ACK, 8'h04);
		rd(`TC_IDX_CTRL);
		c = ctrl_t'(d);
		check({7'h0, c.ext0_flag}, 8'h00);
		// Unit 0 as a gated 16-bit event counter: one fall rolls 0xffff over and sets bit 5.
		wr(`TC_IDX_MODE, 8'h0d);
		wr(`TC_IDX_TL0, 8'hff);
		wr(`TC_IDX_TH0, 8'hff);
		wr(`TC_IDX_IRQEN, 8'h1d);
		wr(`TC_IDX_CTRL, 8'h10);
		burst(4'h1);
		rc(`TC_IDX_CTRL, 8'h30);
		rc(`TC_IDX_TH0, 8'h00);
		check({7'h0, irq0}, 8'h01);
		// Both interrupt pins low in level mode raise their enabled requests.
		ext0_pin <= 1'b0;
		ext1_pin <= 1'b0;
		repeat (5) @(posedge aclk);
		check({6'h0, irqx1, irqx0}, 8'h03);
		conclude();
	end
endmodule : dual_timer_counter_modes_test
`default_nettype wire
